// file: cgst_top.v
// Gated 16-bit counter front end with an 8-bit overflow timer, behind an
// AXI4-Lite register slave.
// Assumes all pins synchronous to core_clk and one write and one read at most
// in flight, as the bus master guarantees.
//
// Behaviour
// - two-bit field selects one of four sources
// - polarity bit clear inverts the chosen source
// - timer wrap FFh to 00h pulses gate
// - external gate pin is a source
// - comparator source synchronised or passed through
// - toggle flop flips on incrementing edges
// - toggle bit clear holds flop clear
`timescale 1ns/1ns
`default_nettype none
`include "cgst_defs.vh"

module cgst_top
(
    // Clock and reset.
    input  wire        core_clk,
    input  wire        arst_n,
    // Write address channel.
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // Write data channel.
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // Write response channel.
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // Read address channel.
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // Read data channel.
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Gate sources.
    input  wire        gateInputPin,
    input  wire        comparatorOneOut,
    input  wire        comparatorTwoOut,
    // Observed state.
    output reg         gateLevel,
    output reg  [15:0] gatedCounter
);

    // Register index codes returned by the address decoder.
    localparam [2:0] IDX_CTRL   = 3'h0;
    localparam [2:0] IDX_STATUS = 3'h1;
    localparam [2:0] IDX_COUNT  = 3'h2;
    localparam [2:0] IDX_TIMER  = 3'h3;
    localparam [2:0] IDX_NONE   = 3'h4;

    reg  [`CGST_CTRL_WIDTH-1:0] ctrl_q;     // Gate control register.
    reg  [7:0]                  timer_q;    // Eight-bit timer count.
    reg                         ovf_q;      // Timer overflow pulse.
    reg  [3:0]                  div_q;      // Counter clock divider.
    reg                         tick_q;     // Counter clock enable pulse.
    reg  [3:0]                  awAddr_q;   // Held write address.
    reg  [31:0]                 wData_q;    // Held write data.
    reg  [3:0]                  wStrb_q;    // Held write strobes.
    wire                        gateNow;    // Conditioned gate.
    wire                        toggleNow;  // Toggle flop state.
    wire                        doWrite;    // Both write halves held.
    wire [2:0]                  wrIdx;      // Decoded write register.
    wire [2:0]                  rdIdx;      // Decoded read register.
    wire                        wrCtrl;     // Write hits control.
    wire                        wrCount;    // Write hits counter.
    wire                        wrTimer;    // Write hits timer.
    wire [15:0]                 cntMerged;  // Counter merged with strobes.
    wire [15:0]                 ctlMerged;  // Control merged with strobes.

    // Maps a byte address onto a register index; misaligned is unmapped.
    function [2:0] regIndex;
        input [3:0] addr;
        begin
            case (addr)
                `CGST_OFS_CTRL:   regIndex = IDX_CTRL;
                `CGST_OFS_STATUS: regIndex = IDX_STATUS;
                `CGST_OFS_COUNT:  regIndex = IDX_COUNT;
                `CGST_OFS_TIMER:  regIndex = IDX_TIMER;
                default:          regIndex = IDX_NONE;
            endcase
        end
    endfunction

    // Applies the two low byte strobes to a 16-bit register value.
    function [15:0] mergeLanes;
        input [15:0] old;
        input [15:0] data;
        input [1:0]  strb;
        begin
            mergeLanes[7:0]  = strb[0] ? data[7:0]  : old[7:0];
            mergeLanes[15:8] = strb[1] ? data[15:8] : old[15:8];
        end
    endfunction

    assign doWrite   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wrIdx     = regIndex(awAddr_q);
    assign rdIdx     = regIndex(s_axi_araddr);
    assign wrCtrl    = doWrite && (wrIdx == IDX_CTRL);
    assign wrCount   = doWrite && (wrIdx == IDX_COUNT);
    assign wrTimer   = doWrite && (wrIdx == IDX_TIMER) && wStrb_q[0];
    assign cntMerged = mergeLanes(gatedCounter, wData_q[15:0], wStrb_q[1:0]);
    assign ctlMerged = mergeLanes({7'h00, ctrl_q}, wData_q[15:0], wStrb_q[1:0]);

    // Divider that makes the counter clock enable.
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_q  <= 4'h0;
            tick_q <= 1'b0;
        end
        else if (div_q == `CGST_TICK_LAST)
        begin
            div_q  <= 4'h0;
            tick_q <= 1'b1;
        end
        else
        begin
            div_q  <= div_q + 4'h1;
            tick_q <= 1'b0;
        end
    end

    // Eight-bit timer; a bus write with byte lane 0 strobed replaces the count.
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            timer_q <= `CGST_TIMER_RESET;
            ovf_q   <= 1'b0;
        end
        else if (wrTimer)
        begin
            timer_q <= wData_q[7:0];
            ovf_q   <= 1'b0;
        end
        else if (ctrl_q[`CGST_CTRL_TIMER_ON])
        begin
            timer_q <= timer_q + 8'h01;
            ovf_q   <= (timer_q == `CGST_TIMER_MAX);
        end
        else
        begin
            ovf_q <= 1'b0;
        end
    end

    // Gate conditioning path.
    cgst_gate_cond u_gate
    (
        .clk           (core_clk),
        .arstN         (arst_n),
        .tick          (tick_q),
        .sourceSel     (ctrl_q[`CGST_CTRL_SEL_HI:`CGST_CTRL_SEL_LO]),
        .polarity      (ctrl_q[`CGST_CTRL_POLARITY]),
        .toggleEn      (ctrl_q[`CGST_CTRL_TOGGLE]),
        .compOneSync   (ctrl_q[`CGST_CTRL_C1_SYNC]),
        .compTwoSync   (ctrl_q[`CGST_CTRL_C2_SYNC]),
        .gatePin       (gateInputPin),
        .overflowPulse (ovf_q),
        .compOne       (comparatorOneOut),
        .compTwo       (comparatorTwoOut),
        .gateOut       (gateNow),
        .toggleState   (toggleNow)
    );

    // Gated counter; a bus write takes priority over counting.
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gatedCounter <= `CGST_COUNT_RESET;
            gateLevel    <= 1'b0;
        end
        else
        begin
            gateLevel <= gateNow;
            if (wrCount)
            begin
                gatedCounter <= cntMerged;
            end
            else if (tick_q && ctrl_q[`CGST_CTRL_COUNT_ON]
                     && (!ctrl_q[`CGST_CTRL_GATE_EN] || gateNow))
            begin
                gatedCounter <= gatedCounter + 16'h0001;
            end
        end
    end

    // Control register; software must not flip toggle and polarity together.
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q <= `CGST_CTRL_RESET;
        end
        else if (wrCtrl)
        begin
            ctrl_q <= ctlMerged[`CGST_CTRL_WIDTH-1:0];
        end
    end

    // Write channels: each half is held until the response is taken.
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CGST_RESP_OKAY;
            awAddr_q      <= 4'h0;
            wData_q       <= 32'h00000000;
            wStrb_q       <= 4'h0;
        end
        else
        begin
            // Address half taken.
            if (s_axi_awready && s_axi_awvalid)
            begin
                awAddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            // Data half taken.
            if (s_axi_wready && s_axi_wvalid)
            begin
                wData_q      <= s_axi_wdata;
                wStrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            // Both halves present: the write lands and the response rises.
            if (doWrite)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wrIdx == IDX_NONE) ? `CGST_RESP_SLVERR
                                                    : `CGST_RESP_OKAY;
            end
            // Response taken: reopen both channels.
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channels: data registered on the same edge that takes the address.
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `CGST_RESP_OKAY;
        end
        else if (s_axi_arready && s_axi_arvalid)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `CGST_RESP_OKAY;
            case (rdIdx)
                IDX_CTRL:   s_axi_rdata <= {23'h000000, ctrl_q};
                IDX_STATUS: s_axi_rdata <= {30'h00000000, toggleNow, gateNow};
                IDX_COUNT:  s_axi_rdata <= {16'h0000, gatedCounter};
                IDX_TIMER:  s_axi_rdata <= {24'h000000, timer_q};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `CGST_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// file: cgst_defs.vh
// Constants for the gated counter front end: register offsets, field positions,
// reset values, bus response codes and the counter clock divider.
// Assumes inclusion by the design files of this block only.
`ifndef CGST_DEFS_VH
`define CGST_DEFS_VH

// Byte offsets of the registers on the register bus.
`define CGST_OFS_CTRL        4'h0
`define CGST_OFS_STATUS      4'h4
`define CGST_OFS_COUNT       4'h8
`define CGST_OFS_TIMER       4'hc

// Field positions in the gate control register.
`define CGST_CTRL_GATE_EN    0
`define CGST_CTRL_COUNT_ON   1
`define CGST_CTRL_SEL_LO     2
`define CGST_CTRL_SEL_HI     3
`define CGST_CTRL_POLARITY   4
`define CGST_CTRL_TOGGLE     5
`define CGST_CTRL_C1_SYNC    6
`define CGST_CTRL_C2_SYNC    7
`define CGST_CTRL_TIMER_ON   8
`define CGST_CTRL_WIDTH      9

// Field positions in the status register.
`define CGST_STAT_GATE       0
`define CGST_STAT_TOGGLE     1

// Gate source select codes.
`define CGST_SRC_PIN         2'h0
`define CGST_SRC_OVERFLOW    2'h1
`define CGST_SRC_COMP_ONE    2'h2
`define CGST_SRC_COMP_TWO    2'h3

// Reset values and the timer wrap value.
`define CGST_CTRL_RESET      9'h000
`define CGST_COUNT_RESET     16'h0000
`define CGST_TIMER_RESET     8'h00
`define CGST_TIMER_MAX       8'hff

// Bus response codes.
`define CGST_RESP_OKAY       2'h0
`define CGST_RESP_SLVERR     2'h2

// Counter clock divider: a tick every (last + 1) core clock cycles.
`define CGST_TICK_LAST       4'h0

`endif

// file: cgst_gate_cond.v
// Gate conditioning path: source select, polarity, optional comparator
// synchronisation and the toggle flip-flop.
// Assumes a single core clock and a one-cycle counter clock enable pulse.
`timescale 1ns/1ns
`default_nettype none
`include "cgst_defs.vh"

module cgst_gate_cond
(
    // Clock, reset and counter clock enable.
    input  wire       clk,
    input  wire       arstN,
    input  wire       tick,
    // Configuration.
    input  wire [1:0] sourceSel,
    input  wire       polarity,
    input  wire       toggleEn,
    input  wire       compOneSync,
    input  wire       compTwoSync,
    // Gate sources.
    input  wire       gatePin,
    input  wire       overflowPulse,
    input  wire       compOne,
    input  wire       compTwo,
    // Conditioned results.
    output wire       gateOut,
    output wire       toggleState
);

    reg  compOne_q;   // Comparator one sampled on the counter clock.
    reg  compTwo_q;   // Comparator two sampled on the counter clock.
    reg  prevGate_q;  // Polarised gate one tick earlier, for edge detect.
    reg  toggle_q;    // Toggle flip-flop.
    reg  selected;    // Chosen raw source.
    wire polarised;   // Source after polarity.
    wire risingEdge;  // Incrementing edge of the polarised gate.

    // Comparators may be sampled on the counter clock or passed straight.
    always @(posedge clk or negedge arstN)
    begin
        if (!arstN)
        begin
            compOne_q <= 1'b0;
            compTwo_q <= 1'b0;
        end
        else if (tick)
        begin
            compOne_q <= compOne;
            compTwo_q <= compTwo;
        end
    end

    // Source multiplexer.
    always @*
    begin
        case (sourceSel)
            `CGST_SRC_PIN:      selected = gatePin;
            `CGST_SRC_OVERFLOW: selected = overflowPulse;
            `CGST_SRC_COMP_ONE: selected = compOneSync ? compOne_q : compOne;
            `CGST_SRC_COMP_TWO: selected = compTwoSync ? compTwo_q : compTwo;
            default:            selected = 1'b0;
        endcase
    end

    assign polarised  = polarity ? selected : ~selected;
    assign risingEdge = polarised & ~prevGate_q;

    // Toggle flip-flop flips on each incrementing edge, seen at tick rate.
    always @(posedge clk or negedge arstN)
    begin
        if (!arstN)
        begin
            prevGate_q <= 1'b0;
            toggle_q   <= 1'b0;
        end
        else
        begin
            if (tick)
            begin
                prevGate_q <= polarised;
            end
            if (!toggleEn)
            begin
                toggle_q <= 1'b0;
            end
            else if (tick && risingEdge)
            begin
                toggle_q <= ~toggle_q;
            end
        end
    end

    // Toggle mode measures a full period rather than one level.
    assign gateOut     = toggleEn ? toggle_q : polarised;
    assign toggleState = toggle_q;

endmodule
`default_nettype wire

// file: cgst_gate_src_model.sv
// Model of the gate sources outside the block: gate pin and two comparators.
// Assumes the bench commands either static levels or a running square wave.
`timescale 1ns/1ns
`default_nettype none
module cgst_gate_src_model
#(
    parameter int HALF = 5
)
(
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Commands from the bench.
    input  wire logic       runWave,
    input  wire logic [2:0] levels,
    // Source levels.
    output var  logic       gateInputPin,
    output var  logic       comparatorOneOut,
    output var  logic       comparatorTwoOut
);
    logic [7:0] cnt;  // Cycles within the current half period.
    logic       wave; // Square wave shared by all sources.

    // The wave stands low while stopped, so every run starts the same way.
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n || !runWave)
        begin
            cnt <= 8'h0;
            wave <= 1'h0;
        end
        else if (cnt == 8'(HALF - 1))
        begin
            cnt <= 8'h0;
            wave <= !wave;
        end
        else
            cnt <= cnt + 8'h1;
    end

    // Static levels unless the wave runs; comparator one runs inverted.
    always_comb
    begin
        gateInputPin = runWave ? wave : levels[0];
        comparatorOneOut = runWave ? !wave : levels[1];
        comparatorTwoOut = runWave ? wave : levels[2];
    end
endmodule
`default_nettype wire

// file: cgst_top_asserts.sv
// Checker for the gated counter: bus answers and the conditioned gate path.
// Assumes writes use strobe lanes 0 and 1, so a control write takes bits 8:0.
`timescale 1ns/1ns
`default_nettype none
module cgst_top_checker
(
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Register bus.
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic        s_axi_bvalid,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Gate path.
    input  wire logic        gateInputPin,
    input  wire logic        gateLevel,
    input  wire logic [15:0] gatedCounter
);
    logic       aSeen;   // Write address taken.
    logic       dSeen;   // Write data taken.
    logic [3:0] aAddr;   // Taken write address.
    logic [8:0] dData;   // Taken write data.
    logic [8:0] ctrlM;   // Mirror of the control register.
    logic       pPrev;   // Polarised pin one cycle ago.
    logic [2:0] ctrlAge; // Cycles since a control write, saturating.
    logic [2:0] riseAge; // Cycles since a polarised pin rise, saturating.
    wire        pinMode = (ctrlM[3:2] == 2'h0) && !ctrlM[5];
    wire        polPin = gateInputPin ~^ ctrlM[4];
    wire        cntOn = ctrlM[1];
    wire        gateOn = ctrlM[0];

    // Mirror the control register; it lands at the edge that raises bvalid.
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aSeen <= 1'h0;
            dSeen <= 1'h0;
            aAddr <= 4'h0;
            dData <= 9'h0;
            ctrlM <= 9'h0;
            pPrev <= 1'h0;
            ctrlAge <= 3'h0;
            riseAge <= 3'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
                {aSeen, aAddr} <= {1'h1, s_axi_awaddr};
            if (s_axi_wvalid && s_axi_wready)
                {dSeen, dData} <= {1'h1, s_axi_wdata[8:0]};
            if (aSeen && dSeen)
                {aSeen, dSeen} <= 2'h0;
            if (aSeen && dSeen && aAddr == 4'h0)
                ctrlM <= dData;
            ctrlAge <= (aSeen && dSeen && aAddr == 4'h0) ? 3'h0 :
                       (ctrlAge == 3'h7 ? ctrlAge : ctrlAge + 3'h1);
            pPrev <= polPin;
            riseAge <= (polPin && !pPrev) ? 3'h0 :
                       (riseAge == 3'h7 ? riseAge : riseAge + 3'h1);
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    sequence arTake;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence bothTaken;
        aSeen && dSeen;
    endsequence

    write_answer_a: assert property (bothTaken |=> s_axi_bvalid)
        else $error("write response late");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answering");
    read_answer_a: assert property (arTake |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("bad address read");
    gate_count_a: assert property (!$rose(s_axi_bvalid) |-> gatedCounter ==
        $past(gatedCounter) + {15'h0, $past(cntOn) && (!$past(gateOn) || gateLevel)})
        else $error("counter step wrong");
    pin_source_a: assert property ($past(arst_n) && $past(pinMode)
        |-> gateLevel == $past(polPin)) else $error("pin gate wrong");
    toggle_edge_a: assert property (ctrlAge > 3'h3 && ctrlM[5] && ctrlM[3:2] == 2'h0
        && $changed(gateLevel) |-> riseAge < 3'h4) else $error("toggle without edge");
    pulse_width_a: assert property (ctrlAge > 3'h1 && ctrlM[3:2] == 2'h1 && ctrlM[4]
        && !ctrlM[5] && gateLevel |=> !gateLevel) else $error("overflow pulse long");
endmodule
bind cgst_top cgst_top_checker chk_u (.core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .gateInputPin, .gateLevel, .gatedCounter);
`default_nettype wire

// file: tb_counter_gate_source_toggle.sv
// Testbench for the gated counter: registers, sources, overflow and toggle.
// Assumes the source model and the bound checker are compiled beforehand.
`timescale 1ns/1ns
`default_nettype none
module tb_counter_gate_source_toggle;
    logic        core_clk = 1'h0;
    logic        arst_n = 1'h0;
    logic [3:0]  awAddr = 4'h0;
    logic [3:0]  arAddr = 4'h0;
    logic [31:0] wData = 32'h0;
    logic        awValid = 1'h0;
    logic        wValid = 1'h0;
    logic        bReady = 1'h0;
    logic        arValid = 1'h0;
    logic        rReady = 1'h0;
    logic        runWave = 1'h0;
    logic [2:0]  lv = 3'h0;
    wire         awReady, wReady, bValid, arReady, rValid, gateLevel, pin, c1, c2;
    wire  [1:0]  bResp, rResp;
    wire  [31:0] rData;
    wire  [15:0] gatedCounter;
    int          n_errors = 0;
    int          cmp_count = 0;

    cgst_top dut_u (.core_clk(core_clk), .arst_n(arst_n), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'h3), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .gateInputPin(pin), .comparatorOneOut(c1),
        .comparatorTwoOut(c2), .gateLevel(gateLevel), .gatedCounter(gatedCounter));
    cgst_gate_src_model src_u (.core_clk(core_clk), .arst_n(arst_n), .runWave(runWave),
        .levels(lv), .gateInputPin(pin), .comparatorOneOut(c1), .comparatorTwoOut(c2));

    // Free-running 50 MHz clock.
    always #10 core_clk = ~core_clk;

    // Compare and count.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bus write; address and data go out together, each dropped once taken.
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'h1;
        wValid <= 1'h1;
        do
        begin
            @(posedge core_clk);
            if (awValid && awReady) awValid <= 1'h0;
            if (wValid && wReady) wValid <= 1'h0;
            if (bValid && !bReady) bReady <= 1'h1;
        end while (!(bValid && bReady));
        r = bResp;
        bReady <= 1'h0;
    endtask

    // Bus read; ready is raised late so the held answer is exercised.
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        arAddr <= a;
        arValid <= 1'h1;
        do
        begin
            @(posedge core_clk);
            if (arValid && arReady) arValid <= 1'h0;
            if (rValid && !rReady) rReady <= 1'h1;
        end while (!(rValid && rReady));
        {d, r} = {rData, rResp};
        rReady <= 1'h0;
    endtask

    task automatic rdChk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, e);
        chk(r, er);
    endtask

    // Counter advance over eight cycles.
    task automatic span(input logic [15:0] exp);
        logic [15:0] c0;
        @(negedge core_clk);
        c0 = gatedCounter;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        chk(16'(gatedCounter - c0), exp);
    endtask

    task automatic waitLvl(input logic v);
        int n;
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end while (gateLevel !== v && n < 300);
    endtask

    // Reset values, bad addresses, read-write registers, ungated counting.
    task automatic tRegs();
        logic [1:0] r;
        rdChk(4'h0, 32'h0, 2'h0);
        rdChk(4'h8, 32'h0, 2'h0);
        rdChk(4'hc, 32'h0, 2'h0);
        rdChk(4'h5, 32'h0, 2'h2);
        wr(4'h6, 32'hffff, r);
        chk(r, 2'h2);
        wr(4'h8, 32'habcd, r);
        wr(4'hc, 32'h5a, r);
        wr(4'h4, 32'h3, r);
        chk(r, 2'h0);
        rdChk(4'h8, 32'habcd, 2'h0);
        chk(gatedCounter, 16'habcd);
        rdChk(4'hc, 32'h5a, 2'h0);
        rdChk(4'h4, 32'h1, 2'h0);
        lv <= 3'h1;
        wr(4'h0, 32'h2, r);
        span(16'h8);
    endtask

    // Every source with both polarities, and both levels except overflow, which stays low; sync bits vary.
    task automatic tSelect();
        logic [1:0] r;
        logic [2:0] v;
        logic       e;
        for (int s = 0; s < 4; s++)
            for (int k = 0; k < 4; k++)
            begin
                v = {3{~k[0]}};
                if (s != 1) v[s == 0 ? 0 : s - 1] = k[0];
                @(posedge core_clk);
                lv <= v;
                e = (s == 1) ? ~k[1] : ~(k[0] ^ k[1]);
                wr(4'h0, {23'h0, 1'h0, k[1], ~k[1], 1'h0, k[1], s[1:0], 2'h3}, r);
                repeat (4) @(posedge core_clk);
                span(e ? 16'h8 : 16'h0);
                chk(gateLevel, e);
            end
    endtask

    // Overflow pulses are a full timer wrap apart and gate one count each.
    task automatic tOverflow();
        logic [1:0]  r;
        logic [15:0] c0;
        int          n;
        wr(4'hc, 32'hf0, r);
        wr(4'h0, 32'h117, r);
        waitLvl(1'h1);
        c0 = gatedCounter;
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end while (gateLevel !== 1'h1 && n < 400);
        chk(n, 32'h100);
        chk(16'(gatedCounter - c0), 16'h1);
    endtask

    // Toggle mode spans a whole pin period; clearing it holds the flop clear.
    task automatic tToggle();
        logic [1:0]  r;
        logic [31:0] d;
        int          n;
        @(posedge core_clk);
        runWave <= 1'h1;
        wr(4'h0, 32'h013, r);
        wr(4'h0, 32'h033, r);
        waitLvl(1'h0);
        waitLvl(1'h1);
        n = 0;
        while (gateLevel === 1'h1 && n < 50)
        begin
            @(negedge core_clk);
            n++;
        end
        chk(n, 32'ha);
        wr(4'h0, 32'h013, r);
        rd(4'h4, d, r);
        chk(d[1], 1'h0);
        runWave <= 1'h0;
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence after ten cycles of reset.
    initial
    begin
        repeat (10) @(posedge core_clk);
        arst_n <= 1'h1;
        tRegs();
        tSelect();
        tOverflow();
        tToggle();
        end_of_test();
    end

    // Watchdog well beyond the expected run.
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
